// ===== prescaler_pkg.sv
package prescaler_pkg;

  // ---------------------------------------------------------------
  // Counter widths and reset values
  // ---------------------------------------------------------------
  localparam int          SYS_W         = 13;
  localparam int          SUB_W         = 5;
  localparam logic [12:0] SYS_RST       = 13'h0000;
  localparam logic [4:0]  SUB_RST       = 5'h00;

  // ---------------------------------------------------------------
  // Watch clock front divider (divide by four)
  // ---------------------------------------------------------------
  localparam int          WDIV_W        = 2;
  localparam logic [1:0]  WDIV_RST      = 2'h0;
  localparam logic [1:0]  WDIV_LAST     = 2'h3;

  // ---------------------------------------------------------------
  // Medium-speed input divider, terminal counts (ratio minus one)
  // ---------------------------------------------------------------
  localparam int          MSDIV_W       = 7;
  localparam logic [6:0]  MSDIV_RST     = 7'h00;
  localparam logic [6:0]  ACT_DIV16     = 7'h0f;
  localparam logic [6:0]  ACT_DIV32     = 7'h1f;
  localparam logic [6:0]  ACT_DIV64     = 7'h3f;
  localparam logic [6:0]  ACT_DIV128    = 7'h7f;
  localparam logic [6:0]  SLP_DIV8      = 7'h07;
  localparam logic [6:0]  SLP_DIV16     = 7'h0f;
  localparam logic [6:0]  SLP_DIV32     = 7'h1f;
  localparam logic [6:0]  SLP_DIV64     = 7'h3f;

  // ---------------------------------------------------------------
  // Peripheral tap selection
  // ---------------------------------------------------------------
  localparam int          NUM_PERIPH    = 10;
  localparam int          TAP_SEL_W     = 5;
  localparam int          WATCH_TAPS    = 8;
  localparam int          NUM_TAPS      = 21;
  localparam logic [4:0]  TAP_SEL_LAST  = 5'h14;
  localparam int          TA_SEL_W      = 3;
  localparam logic [2:0]  TA_SEL_LAST   = 3'h4;

  // ---------------------------------------------------------------
  // Timer A mode register clear-select bit positions
  // ---------------------------------------------------------------
  localparam int          TMA_CLKSRC_BIT3 = 3;
  localparam int          TMA_CLKSRC_BIT2 = 2;

  // ---------------------------------------------------------------
  // Power modes
  // ---------------------------------------------------------------
  typedef enum logic [7:0] {
    MODE_ACTIVE_HS = 8'h01,
    MODE_ACTIVE_MS = 8'h02,
    MODE_SLEEP_HS  = 8'h04,
    MODE_SLEEP_MS  = 8'h08,
    MODE_WATCH     = 8'h10,
    MODE_SUBACTIVE = 8'h20,
    MODE_SUBSLEEP  = 8'h40,
    MODE_STANDBY   = 8'h80
  } power_mode_t;

endpackage

// ===== sync_2ff.sv
`timescale 1ns/10ps
module sync_2ff (
  input  wire logic i_core_clk,
  input  wire logic i_reset,
  input  wire logic i_clk_en,
  input  wire logic i_async,
  output logic      o_sync
);

  // ---------------------------------------------------------------
  // Two-stage synchroniser
  // ---------------------------------------------------------------
  logic meta_r;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      meta_r <= 1'b0;
      o_sync <= 1'b0;
    end else if (i_clk_en) begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end

endmodule

// ===== up_counter.sv
`timescale 1ns/10ps
module up_counter #(
  parameter int              WIDTH = 8,
  parameter logic [WIDTH-1:0] RST  = '0
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_reset,
  input  wire logic             i_clk_en,
  input  wire logic             i_clear,
  input  wire logic             i_inc,
  output logic [WIDTH-1:0]      o_count
);

  // ---------------------------------------------------------------
  // Binary up-counter, clear wins over increment
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] count_nxt;

  assign count_nxt = i_clear ? RST
                   : (i_inc ? WIDTH'(o_count + 1'b1) : o_count);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_count <= RST;
    end else if (i_clk_en) begin
      o_count <= count_nxt;
    end
  end

endmodule

// ===== dual_clock_prescalers.sv
`timescale 1ns/10ps
// Behaviour
// - System prescaler: 13-bit counter, one per period
// - Reset clears system prescaler, counts after release
// - Watch, subactive, subsleep and standby modes stop and clear system prescaler
// - No processor access to system prescaler
// - Shared taps, each peripheral selects its own
// - Active medium-speed input is osc/16..osc/128
// - Medium sleep peripherals at clock/8..clock/64
// - Subclock prescaler: 5-bit counter on watch/4
// - Reset clears subclock prescaler, counts after release
// - Subclock prescaler runs in all low-power modes
// - Both clear-select bits written one clear it
// - Subclock taps offered to timer A as clock
// - Taps: clock/2..8192, watch/1..128
module dual_clock_prescalers (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_reset,
  input  wire logic                      i_clk_en,
  input  prescaler_pkg::power_mode_t     i_power_mode,
  input  wire logic [1:0]                i_ms_div_sel,
  input  wire logic                      i_watch_clk,
  input  wire logic                      i_tma_wr,
  input  wire logic [7:0]                i_tma_wdata,
  input  wire logic [2:0]                i_timer_a_tb_sel,
  input  wire logic [49:0]               i_periph_tap_sel,
  output logic [12:0]                    o_sys_taps,
  output logic [7:0]                     o_watch_taps,
  output logic [9:0]                     o_periph_clk_en,
  output logic                           o_timer_a_clk_en
);

  // ---------------------------------------------------------------
  // Power mode capture
  // ---------------------------------------------------------------
  prescaler_pkg::power_mode_t mode_r;
  logic                       sys_freeze;
  logic                       ms_active;
  logic                       ms_sleep;

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      mode_r <= prescaler_pkg::MODE_ACTIVE_HS;
    end else if (i_clk_en) begin
      mode_r <= i_power_mode;
    end
  end

  always_comb begin
    sys_freeze = 1'b0;
    ms_active  = 1'b0;
    ms_sleep   = 1'b0;
    unique case (mode_r)
      prescaler_pkg::MODE_ACTIVE_HS: begin
        sys_freeze = 1'b0;
      end
      prescaler_pkg::MODE_SLEEP_HS: begin
        sys_freeze = 1'b0;
      end
      prescaler_pkg::MODE_ACTIVE_MS: begin
        ms_active = 1'b1;
      end
      prescaler_pkg::MODE_SLEEP_MS: begin
        ms_sleep = 1'b1;
      end
      prescaler_pkg::MODE_WATCH,
      prescaler_pkg::MODE_SUBACTIVE,
      prescaler_pkg::MODE_SUBSLEEP,
      prescaler_pkg::MODE_STANDBY: begin
        sys_freeze = 1'b1;
      end
      default: begin
        sys_freeze = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Medium-speed input divider
  // ---------------------------------------------------------------
  logic [6:0] ms_cnt_r;
  logic [6:0] ms_cnt_nxt;
  logic [6:0] ms_last;
  logic [6:0] act_last;
  logic [6:0] slp_last;
  logic       ms_mode;
  logic       ms_tick;
  logic       sys_inc;

  assign act_last = (i_ms_div_sel == 2'h0) ? prescaler_pkg::ACT_DIV16
                  : (i_ms_div_sel == 2'h1) ? prescaler_pkg::ACT_DIV32
                  : (i_ms_div_sel == 2'h2) ? prescaler_pkg::ACT_DIV64
                  :                          prescaler_pkg::ACT_DIV128;
  assign slp_last = (i_ms_div_sel == 2'h0) ? prescaler_pkg::SLP_DIV8
                  : (i_ms_div_sel == 2'h1) ? prescaler_pkg::SLP_DIV16
                  : (i_ms_div_sel == 2'h2) ? prescaler_pkg::SLP_DIV32
                  :                          prescaler_pkg::SLP_DIV64;
  assign ms_last  = ms_sleep ? slp_last : act_last;
  assign ms_mode  = ms_active | ms_sleep;
  assign ms_tick  = ms_mode & (ms_cnt_r >= ms_last);
  assign ms_cnt_nxt = (!ms_mode || ms_tick) ? prescaler_pkg::MSDIV_RST
                    : 7'(ms_cnt_r + 1'b1);
  assign sys_inc  = !sys_freeze && (!ms_mode || ms_tick);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ms_cnt_r <= prescaler_pkg::MSDIV_RST;
    end else if (i_clk_en) begin
      ms_cnt_r <= ms_cnt_nxt;
    end
  end

  // ---------------------------------------------------------------
  // System-clock prescaler
  // ---------------------------------------------------------------
  // Count has no path to any processor port
  up_counter #(
    .WIDTH (prescaler_pkg::SYS_W),
    .RST   (prescaler_pkg::SYS_RST)
  ) u_sysclk_prescaler (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_clear    (sys_freeze),
    .i_inc      (sys_inc),
    .o_count    (o_sys_taps)
  );

  // ---------------------------------------------------------------
  // Watch clock synchroniser and divide by four
  // ---------------------------------------------------------------
  logic       watch_s;
  logic       watch_d_r;
  logic       watch_rise;
  logic [1:0] wdiv_r;
  logic [1:0] wdiv_nxt;
  logic       sub_inc;

  sync_2ff u_watch_sync (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_async    (i_watch_clk),
    .o_sync     (watch_s)
  );

  assign watch_rise = watch_s & ~watch_d_r;
  assign wdiv_nxt   = watch_rise ? 2'(wdiv_r + 1'b1) : wdiv_r;
  assign sub_inc    = watch_rise && (wdiv_r == prescaler_pkg::WDIV_LAST);

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      watch_d_r <= 1'b0;
      wdiv_r    <= prescaler_pkg::WDIV_RST;
    end else if (i_clk_en) begin
      watch_d_r <= watch_s;
      wdiv_r    <= wdiv_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Subclock prescaler
  // ---------------------------------------------------------------
  logic [4:0] sub_cnt;
  logic       sub_clear;

  assign sub_clear = i_tma_wr
                   & i_tma_wdata[prescaler_pkg::TMA_CLKSRC_BIT3]
                   & i_tma_wdata[prescaler_pkg::TMA_CLKSRC_BIT2];

  // Not gated by the power mode
  up_counter #(
    .WIDTH (prescaler_pkg::SUB_W),
    .RST   (prescaler_pkg::SUB_RST)
  ) u_subclk_prescaler (
    .i_core_clk (i_core_clk),
    .i_reset    (i_reset),
    .i_clk_en   (i_clk_en),
    .i_clear    (sub_clear),
    .i_inc      (sub_inc),
    .o_count    (sub_cnt)
  );

  // Watch taps: undivided, /2, /4, then /8../128 from the counter
  assign o_watch_taps = {sub_cnt, wdiv_r, watch_d_r};

  // ---------------------------------------------------------------
  // Timer A time base
  // ---------------------------------------------------------------
  logic [2:0] ta_sel;
  logic       ta_tap;
  logic       ta_tap_r;

  assign ta_sel = (i_timer_a_tb_sel > prescaler_pkg::TA_SEL_LAST)
                ? prescaler_pkg::TA_SEL_LAST : i_timer_a_tb_sel;
  assign ta_tap = sub_cnt[ta_sel];

  always_ff @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      ta_tap_r         <= 1'b0;
      o_timer_a_clk_en <= 1'b0;
    end else if (i_clk_en) begin
      ta_tap_r         <= ta_tap;
      o_timer_a_clk_en <= ta_tap & ~ta_tap_r;
    end
  end

  // ---------------------------------------------------------------
  // Per-peripheral tap selection
  // ---------------------------------------------------------------
  logic [20:0] all_taps;

  assign all_taps = {o_watch_taps, o_sys_taps};

  genvar gi;
  generate
    for (gi = 0; gi < prescaler_pkg::NUM_PERIPH; gi++) begin : g_periph
      logic [4:0] sel;
      logic       tap;
      logic       tap_r;

      assign sel = i_periph_tap_sel[gi*prescaler_pkg::TAP_SEL_W +:
                                    prescaler_pkg::TAP_SEL_W];
      assign tap = (sel > prescaler_pkg::TAP_SEL_LAST) ? 1'b0
                 : all_taps[sel];

      always_ff @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          tap_r               <= 1'b0;
          o_periph_clk_en[gi] <= 1'b0;
        end else if (i_clk_en) begin
          tap_r               <= tap;
          o_periph_clk_en[gi] <= tap & ~tap_r;
        end
      end
    end
  endgenerate

endmodule

// ===== dual_clock_prescalers_checker.sv
`timescale 1ns/10ps
module dual_clock_prescalers_checker (
  input wire logic                  i_core_clk,
  input wire logic                  i_reset,
  input wire logic                  i_clk_en,
  input prescaler_pkg::power_mode_t i_power_mode,
  input wire logic [1:0]            i_ms_div_sel,
  input wire logic                  i_watch_clk,
  input wire logic                  i_tma_wr,
  input wire logic [7:0]            i_tma_wdata,
  input wire logic [2:0]            i_timer_a_tb_sel,
  input wire logic [49:0]           i_periph_tap_sel,
  input wire logic [12:0]           o_sys_taps,
  input wire logic [7:0]            o_watch_taps,
  input wire logic [9:0]            o_periph_clk_en,
  input wire logic                  o_timer_a_clk_en
);
  // ------
  // Helpers
  // ------
  wire logic [20:0] taps = {o_watch_taps, o_sys_taps};
  wire logic [4:0]  sel0 = i_periph_tap_sel[4:0];
  wire logic        tap0 = (sel0 <= 5'h14) ? taps[sel0] : 1'b0;
  wire logic [2:0]  ta   = (i_timer_a_tb_sel > 3'h4) ? 3'h4 : i_timer_a_tb_sel;
  wire logic        tab  = o_watch_taps[3'h3 + ta];
  wire logic [4:0]  sub  = o_watch_taps[7:3];

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  // ------
  // Assertions
  // ------
  sys_count_a: assert property (
    !$past(i_reset) && $past(i_clk_en) && $past(i_clk_en, 2) &&
    $past(i_power_mode, 2) == prescaler_pkg::MODE_ACTIVE_HS
    |-> o_sys_taps == $past(o_sys_taps) + 13'h1)
    else $error("system prescaler missed a step");
  sys_frozen_a: assert property (
    !$past(i_reset, 2) && $past(i_clk_en) && $past(i_clk_en, 2) &&
    $past(i_power_mode[7:4], 2) != 4'h0 |-> o_sys_taps == 13'h0)
    else $error("system prescaler not held clear");
  reset_start_a: assert property (
    $past(i_reset) && i_clk_en |-> o_sys_taps == 13'h0 &&
    o_watch_taps == 8'h0 ##1 o_sys_taps == 13'h1)
    else $error("prescalers wrong after reset");
  tma_clear_a: assert property (
    i_clk_en && i_tma_wr && i_tma_wdata[3] && i_tma_wdata[2]
    |=> sub == 5'h0)
    else $error("subclock prescaler not cleared");
  sub_step_a: assert property (
    sub != $past(sub) && sub != 5'h0 |->
    sub == $past(sub) + 5'h1 && $past(o_watch_taps[2:1]) == 2'h3)
    else $error("subclock prescaler bad step");
  ta_pulse_a: assert property (
    $rose(tab) && $stable(ta) && i_clk_en |-> ##[1:2] o_timer_a_clk_en)
    else $error("timer A pulse missing");
  tap_pulse_a: assert property (
    $rose(tap0) && $stable(sel0) && i_clk_en
    |-> ##[1:2] o_periph_clk_en[0])
    else $error("peripheral pulse missing");
  no_tap_a: assert property (
    $past(sel0) > 5'h14 && $past(sel0, 2) > 5'h14 |-> !o_periph_clk_en[0])
    else $error("pulse with no tap selected");
endmodule

bind dual_clock_prescalers dual_clock_prescalers_checker u_chk (
  .i_core_clk(i_core_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
  .i_power_mode(i_power_mode), .i_ms_div_sel(i_ms_div_sel),
  .i_watch_clk(i_watch_clk), .i_tma_wr(i_tma_wr),
  .i_tma_wdata(i_tma_wdata), .i_timer_a_tb_sel(i_timer_a_tb_sel),
  .i_periph_tap_sel(i_periph_tap_sel), .o_sys_taps(o_sys_taps),
  .o_watch_taps(o_watch_taps), .o_periph_clk_en(o_periph_clk_en),
  .o_timer_a_clk_en(o_timer_a_clk_en));

// ===== watch_osc_model.sv
`timescale 1ns/10ps
module watch_osc_model #(
  parameter real HALF_NS = 26.35
) (
  input  wire logic i_run,
  output logic      o_watch_clk
);
  // ------
  // Watch oscillator, low while stopped
  // ------
  initial o_watch_clk = 1'b0;
  always begin
    #(HALF_NS);
    o_watch_clk = i_run ? ~o_watch_clk : 1'b0;
  end
endmodule

// ===== dual_clock_prescalers_test.sv
`timescale 1ns/10ps
module dual_clock_prescalers_test;
  logic                       i_core_clk;
  logic                       i_reset;
  logic                       i_clk_en;
  prescaler_pkg::power_mode_t i_power_mode;
  logic [1:0]                 i_ms_div_sel;
  wire logic                  i_watch_clk;
  logic                       i_tma_wr;
  logic [7:0]                 i_tma_wdata;
  logic [2:0]                 i_timer_a_tb_sel;
  logic [49:0]                i_periph_tap_sel;
  logic [12:0]                o_sys_taps;
  logic [7:0]                 o_watch_taps;
  logic [9:0]                 o_periph_clk_en;
  logic                       o_timer_a_clk_en;
  int                         err_count;
  int                         check_count;
  wire logic [4:0]            sub = o_watch_taps[7:3];

  dual_clock_prescalers DUT (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
    .i_power_mode(i_power_mode), .i_ms_div_sel(i_ms_div_sel),
    .i_watch_clk(i_watch_clk), .i_tma_wr(i_tma_wr),
    .i_tma_wdata(i_tma_wdata), .i_timer_a_tb_sel(i_timer_a_tb_sel),
    .i_periph_tap_sel(i_periph_tap_sel), .o_sys_taps(o_sys_taps),
    .o_watch_taps(o_watch_taps), .o_periph_clk_en(o_periph_clk_en),
    .o_timer_a_clk_en(o_timer_a_clk_en));
  watch_osc_model osc (.i_run(1'b1), .o_watch_clk(i_watch_clk));

  always #2 i_core_clk = ~i_core_clk;

  // ------
  // Helpers
  // ------
  task automatic chk(input string nm, input logic [12:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask

  task automatic wchg(output int n);
    logic [12:0] v;
    v = o_sys_taps;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (o_sys_taps === v && n < 300);
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    i_reset = 1'b1;
    tick(16);
    i_reset = 1'b0;
    chk("rst_sys", o_sys_taps, 13'h0);
    chk("rst_sub", 13'(o_watch_taps), 13'h0);
    tick(1);
    chk("first", o_sys_taps, 13'h1);
  endtask

  task automatic t_hs;
    logic [12:0] v;
    v = o_sys_taps;
    tick(100);
    chk("hs", o_sys_taps, v + 13'h64);
    i_clk_en = 1'b0;
    v = o_sys_taps;
    tick(10);
    chk("hold", o_sys_taps, v);
    i_clk_en = 1'b1;
    i_power_mode = prescaler_pkg::MODE_SLEEP_HS;
    v = o_sys_taps;
    tick(50);
    chk("slp_hs", o_sys_taps, v + 13'h32);
  endtask

  task automatic t_low;
    logic [4:0] s;
    for (int i = 4; i < 9; i++) begin
      i_power_mode = prescaler_pkg::power_mode_t'(8'h01 << i);
      s = sub;
      tick(2);
      chk("frz", o_sys_taps, 13'h0);
      tick(200);
      chk("frz", o_sys_taps, 13'h0);
      chk("sub_run", 13'(sub != s), 13'h1);
      i_power_mode = prescaler_pkg::MODE_ACTIVE_HS;
      tick(2);
      chk("wake", o_sys_taps, 13'h1);
    end
  endtask

  task automatic t_med;
    int n;
    for (int i = 0; i < 8; i++) begin
      i_power_mode = i[2] ? prescaler_pkg::MODE_SLEEP_MS
                          : prescaler_pkg::MODE_ACTIVE_MS;
      i_ms_div_sel = i[1:0];
      wchg(n);
      wchg(n);
      chk("ratio", 13'(n), 13'((i[2] ? 8 : 16) << i[1:0]));
    end
    i_power_mode = prescaler_pkg::MODE_ACTIVE_HS;
    tick(2);
  endtask

  task automatic t_clear;
    logic [7:0] wd[4] = '{8'h08, 8'h04, 8'h0c, 8'hff};
    logic [4:0] s;
    logic [12:0] v;
    int n;
    foreach (wd[k]) begin
      n = 0;
      while ((sub == 5'h0 || sub == 5'h1f) && n < 300) begin
        tick(1);
        n++;
      end
      s = sub;
      v = o_sys_taps;
      i_tma_wdata = wd[k];
      i_tma_wr = 1'b1;
      tick(1);
      i_tma_wr = 1'b0;
      chk("no_cpu", o_sys_taps, v + 13'h1);
      if (wd[k][3] && wd[k][2])
        chk("clr", 13'(sub), 13'h0);
      else
        chk("keep", 13'(5'(sub - s) <= 5'h1), 13'h1);
      tick(1);
    end
  endtask

  task automatic t_taps;
    int c[10] = '{default: 0};
    int n;
    i_periph_tap_sel = {5'h0d, 30'h3fffffff, 5'h15, 5'h03, 5'h00};
    tick(4);
    repeat (64) begin
      tick(1);
      foreach (c[k])
        c[k] += o_periph_clk_en[k];
    end
    chk("p0", 13'(c[0]), 13'h20);
    chk("p1", 13'(c[1]), 13'h4);
    for (int k = 2; k < 9; k++)
      chk("pnone", 13'(c[k]), 13'h0);
    chk("p9", 13'(c[9] inside {4, 5}), 13'h1);
    n = 0;
    while (o_timer_a_clk_en !== 1'b1 && n < 300) begin
      tick(1);
      n++;
    end
    chk("ta", 13'(o_timer_a_clk_en), 13'h1);
    i_timer_a_tb_sel = 3'h7;
    tick(3500);
  endtask

  // ------
  // Main sequence and watchdog
  // ------
  initial begin
    i_core_clk = 1'b0;
    i_reset = 1'b1;
    i_clk_en = 1'b1;
    i_power_mode = prescaler_pkg::MODE_ACTIVE_HS;
    i_ms_div_sel = 2'h0;
    i_tma_wr = 1'b0;
    i_tma_wdata = 8'h00;
    i_timer_a_tb_sel = 3'h0;
    i_periph_tap_sel = {50{1'b1}};
    err_count = 0;
    check_count = 0;
    t_reset;
    t_hs;
    t_low;
    t_med;
    t_clear;
    t_taps;
    results;
  end

  initial begin
    #80000;
    err_count++;
    results;
  end
endmodule
